// ### include/adc_warmup_defines.svh
// offsets, field positions, reset values and delay figures for the
// core warm-up and ready-interrupt block; definitions only
`ifndef ADC_WARMUP_DEFINES_SVH
`define ADC_WARMUP_DEFINES_SVH

// register byte offsets on the plain register port
`define WU_OFS_CTRL      8'h00
`define WU_OFS_STATUS    8'h04
`define WU_OFS_MASK      8'h08
`define WU_OFS_READY     8'h0c

// control register fields
`define WU_DLY_MSB       11
`define WU_DLY_LSB       8
`define WU_SHR_EN_BIT    7
`define WU_DED_EN_MSB    3
`define WU_CTRL_WMASK    16'h0f8f
`define WU_CTRL_RESET    16'h0000
`define WU_MASK_RESET    16'h0000

// warm-up delays in core source clock periods (one period = one cycle)
`define WU_DLY_MIN_CODE  4'h4
`define WU_DLY_FLOOR     16'h0010
`define WU_DLY_32768     16'h8000
`define WU_DLY_16384     16'h4000
`define WU_DLY_8192      16'h2000
`define WU_DLY_4096      16'h1000
`define WU_DLY_2048      16'h0800
`define WU_DLY_512       16'h0200

`endif

// ### include/adc_warmup_pkg.sv
// types shared by the core warm-up and ready-interrupt block
package adc_warmup_pkg;
   typedef logic [15:0] reg_data_t;
   typedef logic [15:0] delay_t;
   typedef logic [7:0]  reg_addr_t;
   typedef logic [3:0]  delay_code_t;
endpackage

// ### verilog/adc_core_warmup_ready_irq.sv
// core power-up warm-up timer and ready interrupt control for four
// dedicated converter cores and one shared core.
// assumes clk_in is the core source clock and power enables come from
// logic on the same clock; registers on a plain strobe port.
//
// Functional notes
// R1: bits 11..8 set one delay for all cores; f, e, d: 32768, 16384, 8192.
// R2: code 1100 gives 4096 periods and code 1011 gives 2048 periods.
// R3: code 1001 gives 512 periods.
// R4: a set dedicated enable bit (3..0) lets its core's ready raise the irq.
// R5: with that enable bit clear, its ready event leaves the irq alone.
// R6: ready comes the delay after power enable; bit 7 gates the shared core.
`timescale 1ns/1ps
`include "adc_warmup_defines.svh"

module adc_core_warmup_ready_irq #(
   parameter int unsigned NUM_CORES  = 5,
   parameter int unsigned WARMUP_CAP = 32768
) (
   // clock and reset
   input  wire logic                      clk_in,
   input  wire logic                      rst_in,
   // register port
   input  wire adc_warmup_pkg::reg_addr_t addr_in,
   input  wire adc_warmup_pkg::reg_data_t wdata_in,
   input  wire logic                      wr_in,
   input  wire logic                      rd_in,
   output adc_warmup_pkg::reg_data_t      rdata_out,
   // cores: bits 3..0 dedicated, bit 4 shared
   input  wire logic [NUM_CORES-1:0]      core_pwr_en_in,
   output logic [NUM_CORES-1:0]           core_ready_out,
   output logic [NUM_CORES-1:0]           core_ready_evt_out,
   // common interrupt
   output logic                           irq_out
);

   adc_warmup_pkg::reg_data_t   ctrl_reg;
   adc_warmup_pkg::reg_data_t   mask_reg;
   adc_warmup_pkg::reg_data_t   rdata_reg;
   logic [NUM_CORES-1:0]        status_reg;
   logic [NUM_CORES-1:0]        status_next;
   logic [NUM_CORES-1:0]        ready_reg;
   logic [NUM_CORES-1:0]        evt_reg;
   logic [NUM_CORES-1:0]        evt_now;
   logic [NUM_CORES-1:0]        irq_en;
   logic [NUM_CORES-1:0]        mask_bits;
   logic [15:0]                 cnt_reg [NUM_CORES];
   adc_warmup_pkg::delay_code_t dly_code;
   adc_warmup_pkg::delay_t      dly_raw;
   adc_warmup_pkg::delay_t      dly_sel;
   adc_warmup_pkg::delay_t      dly_last;
   adc_warmup_pkg::reg_data_t   rd_mux;
   logic                        sel_ctrl;
   logic                        sel_status;
   logic                        sel_mask;
   logic                        sel_ready;
   logic                        status_clr;
   logic                        rd_valid_reg;

   // maps the five core bits onto the 3..0 / 7 register layout
   function automatic adc_warmup_pkg::reg_data_t to_layout(
      input logic [NUM_CORES-1:0] v);
      adc_warmup_pkg::reg_data_t r;
      r = 16'h0000;
      r[`WU_DED_EN_MSB:0] = v[3:0];
      r[`WU_SHR_EN_BIT] = v[4];
      return r;
   endfunction

   // address decode
   assign sel_ctrl   = (addr_in == `WU_OFS_CTRL);
   assign sel_status = (addr_in == `WU_OFS_STATUS);
   assign sel_mask   = (addr_in == `WU_OFS_MASK);
   assign sel_ready  = (addr_in == `WU_OFS_READY);
   assign status_clr = rd_in && sel_status;

   // warm-up delay: codes 0000..0011 all floor at 16, above that 2^code
   assign dly_code = ctrl_reg[`WU_DLY_MSB:`WU_DLY_LSB];
   assign dly_raw  = (dly_code < `WU_DLY_MIN_CODE) ? `WU_DLY_FLOOR
                     : (16'h0001 << dly_code);             // [R1] [R2] [R3]
   // cap only exists to shorten simulation; default keeps every code
   assign dly_sel  = (32'(dly_raw) > WARMUP_CAP) ? 16'(WARMUP_CAP)
                     : dly_raw;
   assign dly_last = dly_sel - 16'h0001;

   // per-core enable and mask picked out of the register layout
   assign irq_en    = {ctrl_reg[`WU_SHR_EN_BIT],
                       ctrl_reg[`WU_DED_EN_MSB:0]};        // [R6]
   assign mask_bits = {mask_reg[`WU_SHR_EN_BIT],
                       mask_reg[`WU_DED_EN_MSB:0]};

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CORES; gi++) begin : g_core
         // delay is read live, so a change during warm-up retargets it
         assign evt_now[gi] = core_pwr_en_in[gi] && !ready_reg[gi] &&
                              (cnt_reg[gi] == dly_last);    // [R6]
         always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
               cnt_reg[gi]   <= 16'h0000;
               ready_reg[gi] <= 1'b0;
            end else if (!core_pwr_en_in[gi]) begin
               cnt_reg[gi]   <= 16'h0000;
               ready_reg[gi] <= 1'b0;
            end else if (!ready_reg[gi]) begin
               cnt_reg[gi]   <= cnt_reg[gi] + 16'h0001;     // [R6]
               ready_reg[gi] <= evt_now[gi];
            end
         end
      end
   endgenerate

   // sticky status; a new event wins over the read that clears it
   assign status_next = (status_clr ? '0 : status_reg) |
                        (evt_now & irq_en);                 // [R4] [R5]

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         status_reg <= '0;
         evt_reg    <= '0;
      end else begin
         status_reg <= status_next;
         evt_reg    <= evt_now;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl_reg <= `WU_CTRL_RESET;
         mask_reg <= `WU_MASK_RESET;
      end else if (wr_in) begin
         if (sel_ctrl)
            ctrl_reg <= wdata_in & `WU_CTRL_WMASK;
         if (sel_mask)
            mask_reg <= wdata_in & `WU_CTRL_WMASK;
      end
   end

   // read mux; unmapped addresses read zero
   assign rd_mux = sel_ctrl   ? ctrl_reg :
                   sel_status ? to_layout(status_reg) :
                   sel_mask   ? mask_reg :
                   sel_ready  ? to_layout(ready_reg) : 16'h0000;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_reg    <= 16'h0000;
         rd_valid_reg <= 1'b0;
      end else begin
         rdata_reg    <= rd_in ? rd_mux : 16'h0000;
         rd_valid_reg <= rd_in;
      end
   end

   assign rdata_out          = rdata_reg;
   assign core_ready_out     = ready_reg;
   assign core_ready_evt_out = evt_reg;
   assign irq_out            = |(status_reg & mask_bits);   // [R4]

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   dly_top_codes_a: assert property (                        // [R1]
      (dly_code == 4'hf |-> dly_raw == `WU_DLY_32768) and
      (dly_code == 4'he |-> dly_raw == `WU_DLY_16384) and
      (dly_code == 4'hd |-> dly_raw == `WU_DLY_8192))
      else $error("warm-up delay wrong for codes f, e or d");
   dly_mid_codes_a: assert property (                        // [R2]
      (dly_code == 4'hc |-> dly_raw == `WU_DLY_4096) and
      (dly_code == 4'hb |-> dly_raw == `WU_DLY_2048))
      else $error("warm-up delay wrong for codes c or b");
   dly_code9_a: assert property (                            // [R3]
      dly_code == 4'h9 |-> dly_raw == `WU_DLY_512)
      else $error("warm-up delay wrong for code 9");
   dly_floor_a: assert property (
      dly_code < `WU_DLY_MIN_CODE |-> dly_raw == `WU_DLY_FLOOR)
      else $error("warm-up delay wrong for a short code");
   read_clear_a: assert property (                           // [R4]
      status_clr && !(|(evt_now & irq_en)) |=> status_reg == '0)
      else $error("status read left a bit set");
   irq_hold_a: assert property (                             // [R4]
      !wr_in && (status_reg & mask_bits) != '0 && !status_clr
      |=> irq_out)
      else $error("unmasked status bit did not hold interrupt");

   // a stale word on the read port would look like a real answer
   rdata_idle_a: assert property (
      !rd_valid_reg |-> rdata_out == 16'h0000)
      else $error("read data shown outside its cycle");

   generate
      for (gi = 0; gi < NUM_CORES; gi++) begin : g_chk
         ready_sets_irq_a: assert property (                 // [R4]
            evt_now[gi] && irq_en[gi] && mask_bits[gi] && !wr_in
            |=> status_reg[gi] && irq_out)
            else $error("enabled ready event did not raise interrupt");
         disabled_no_set_a: assert property (                // [R5]
            evt_now[gi] && !irq_en[gi] && !status_reg[gi]
            |=> !status_reg[gi])
            else $error("disabled ready event set status");
         warmup_count_a: assert property (                   // [R6]
            $rose(ready_reg[gi]) |-> $past(core_pwr_en_in[gi]) &&
            $past(cnt_reg[gi]) == $past(dly_last))
            else $error("core went ready before its warm-up count");
         pwr_off_clear_a: assert property (                  // [R6]
            !core_pwr_en_in[gi] |=> !ready_reg[gi] && cnt_reg[gi] == 0)
            else $error("core ready held without power enable");
         evt_pulse_a: assert property (                      // [R6]
            evt_reg[gi] == $rose(ready_reg[gi]))
            else $error("ready pulse not on the rising ready edge");
         ready_hold_a: assert property (                     // [R6]
            ready_reg[gi] && core_pwr_en_in[gi] |=> ready_reg[gi])
            else $error("core lost ready while powered");
         status_src_a: assert property (                     // [R4]
            $rose(status_reg[gi]) |-> $rose(ready_reg[gi]))
            else $error("status bit set without a ready event");
      end
   endgenerate

   ready_event_c: cover property ($rose(irq_out));
   clear_race_c:  cover property (status_clr && |(evt_now & irq_en));
   pwr_drop_c:    cover property (ready_reg[0] ##1 !ready_reg[0]);
   shared_rdy_c:  cover property ($rose(ready_reg[4]));
   masked_c:      cover property (|status_reg && !irq_out);

endmodule

// ### test/test_adc_core_warmup_ready_irq.sv
// bench for the core warm-up and ready-interrupt block
// assumes the default cap, so every documented delay is timed in full
`timescale 1ns/1ps
`include "adc_warmup_defines.svh"

module test_adc_core_warmup_ready_irq;
   logic                      clk_in;
   logic                      rst_in;
   logic                      wr_in;
   logic                      rd_in;
   logic                      irq_out;
   adc_warmup_pkg::reg_addr_t addr_in;
   adc_warmup_pkg::reg_data_t wdata_in;
   adc_warmup_pkg::reg_data_t rdata_out;
   logic [4:0]                pwr;
   logic [4:0]                rdy;
   logic [4:0]                evt;
   int                        miscompares;
   int                        n_checks;

   adc_core_warmup_ready_irq dut_u (
      .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .core_pwr_en_in(pwr),
      .core_ready_out(rdy), .core_ready_evt_out(evt), .irq_out(irq_out));

   function automatic int exp_dly(input logic [3:0] c);
      return (c < 4) ? 16 : (1 << c);
   endfunction

   // core bits 3..0 stay in place, the shared core sits at bit 7
   function automatic logic [15:0] layout(input logic [4:0] v);
      return {8'h00, v[4], 3'b000, v[3:0]};
   endfunction

   task automatic wrap_up;
      if (miscompares == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input logic [15:0] got, exp, input string what);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_in);
      wr_in    <= 1'b1;
      addr_in  <= a;
      wdata_in <= d;
      @(posedge clk_in);
      wr_in <= 1'b0;
      #1;
   endtask

   // read data live only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk_in);
      rd_in   <= 1'b1;
      addr_in <= a;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1;
      check(rdata_out, e, "read");
   endtask

   // power cores in m, count edges until all are ready, then check pulse
   task automatic warm(input logic [4:0] m, output int n);
      @(posedge clk_in);
      pwr <= m;
      n = 0;
      do begin
         @(posedge clk_in);
         #1;
         n++;
      end while (rdy !== m && n < 40000);
      if (n >= 40000) begin
         miscompares++;
         $display("[ERR] %0t ready never rose", $time);
         wrap_up();
      end else begin
         // the pulse stands only in the cycle in which ready rises
         check({11'h000, evt}, {11'h000, m}, "ready pulse");
         @(posedge clk_in);
         #1;
         check({11'h000, evt}, 16'h0000, "pulse length");
         rd(`WU_OFS_READY, layout(m));
         @(posedge clk_in);
         pwr <= 5'h00;
         @(posedge clk_in);
         #1;
         check({11'h000, rdy}, 16'h0000, "ready after power off");
      end
   endtask

   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end

   initial begin
      int          n;
      logic [15:0] c;
      logic [3:0]  codes [9];
      codes = '{4'hf, 4'he, 4'hd, 4'hc, 4'hb, 4'ha, 4'h9, 4'h8, 4'h2};
      rst_in = 1'b1;
      wr_in = 1'b0;
      rd_in = 1'b0;
      addr_in = 8'h00;
      wdata_in = 16'h0000;
      pwr = 5'h00;
      miscompares = 0;
      n_checks = 0;
      void'($urandom(32'he04ac607));
      repeat (8) @(posedge clk_in);
      rst_in <= 1'b0;
      rd(`WU_OFS_CTRL, `WU_CTRL_RESET);
      rd(`WU_OFS_MASK, `WU_MASK_RESET);
      wr(`WU_OFS_CTRL, 16'hffff);
      rd(`WU_OFS_CTRL, `WU_CTRL_WMASK);
      wr(8'h10, 16'hffff);
      rd(8'h10, 16'h0000);
      // one delay for all cores: every core must go ready together
      foreach (codes[i]) begin
         wr(`WU_OFS_CTRL, {4'h0, codes[i], 8'h00});
         warm(5'h1f, n);
         check(16'(n), 16'(exp_dly(codes[i])), "delay");
      end
      wr(`WU_OFS_MASK, 16'h008f);
      for (int i = 0; i < 8; i++) begin
         c = (i == 0) ? 16'h0000 : (i == 1) ? 16'h008f
                      : 16'($urandom) & 16'h008f;
         wr(`WU_OFS_CTRL, c | 16'h0400);
         warm(5'h1f, n);
         check(16'(irq_out), 16'(c != 0), "irq raised");
         wr(`WU_OFS_MASK, 16'h0000);
         check(16'(irq_out), 16'h0000, "irq masked");
         wr(`WU_OFS_MASK, 16'h008f);
         rd(`WU_OFS_STATUS, c);
         check(16'(irq_out), 16'h0000, "irq after clear");
      end
      // reset mid-run drops sticky status, enables and mask at once
      wr(`WU_OFS_CTRL, 16'h048f);
      warm(5'h1f, n);
      check(16'(irq_out), 16'h0001, "irq before reset");
      @(posedge clk_in);
      rst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      #1;
      check(16'(irq_out), 16'h0000, "irq after reset");
      rd(`WU_OFS_CTRL, `WU_CTRL_RESET);
      rd(`WU_OFS_MASK, `WU_MASK_RESET);
      rd(`WU_OFS_STATUS, 16'h0000);
      wrap_up();
   end
endmodule
